// ===== hw/clk_cfg_pkg.sv
// package of offsets, field positions and reset values for the clock configuration bank
// assumes word-aligned single transfers on an AHB-Lite bus, byte address = 4 x index
package clk_cfg_pkg;

    // register indices, byte address is four times the index
    localparam logic [7:0] REF_CTL_IDX = 8'h1D;
    localparam logic [7:0] CHANNEL_POWER_DOWN_IDX = 8'h1E;
    localparam logic [7:0] OUT0_IDX = 8'h1F;
    localparam logic [31:0] REF_CTL_ADDR = {22'h000000, REF_CTL_IDX, 2'b00};
    localparam logic [31:0] CHANNEL_POWER_DOWN_ADDR = {22'h000000, CHANNEL_POWER_DOWN_IDX, 2'b00};
    localparam logic [31:0] OUT0_ADDR = {22'h000000, OUT0_IDX, 2'b00};

    // register selector carried from address phase to data phase
    localparam logic [1:0] SEL_REF = 2'h0;
    localparam logic [1:0] SEL_CHANNEL_POWER_DOWN = 2'h1;
    localparam logic [1:0] SEL_OUT0 = 2'h2;
    localparam logic [1:0] SEL_NONE = 2'h3;

    // reference input control fields
    localparam int REF_BYPASS_BIT = 7;
    localparam int REF_SEC_GND_BIT = 5;
    localparam int REF_PRI_GND_BIT = 4;
    localparam int REF_SEC_DIFF_BIT = 3;
    localparam int REF_PRI_DIFF_BIT = 2;
    localparam int REF_SEC_AC_BIT = 1;
    localparam int REF_PRI_AC_BIT = 0;

    // power-down fields
    localparam int CHANNEL_POWER_DOWN_CMOS_BIT = 6;
    localparam int CHANNEL_POWER_DOWN_CH7_BIT = 5;
    localparam int CHANNEL_POWER_DOWN_CH6_BIT = 4;
    localparam int CHANNEL_POWER_DOWN_CH5_BIT = 3;
    localparam int CHANNEL_POWER_DOWN_CH4_BIT = 2;
    localparam int CHANNEL_POWER_DOWN_CH23_BIT = 1;
    localparam int CHANNEL_POWER_DOWN_CH01_BIT = 0;

    // output zero control fields
    localparam int OUT0_SRC_BIT = 7;
    localparam int OUT0_FMT_HI = 6;
    localparam int OUT0_FMT_LO = 5;
    localparam int OUT0_M1_HI = 4;
    localparam int OUT0_M1_LO = 3;
    localparam int OUT0_M2_HI = 2;
    localparam int OUT0_M2_LO = 1;

    // driver format codes
    localparam logic [1:0] FMT_DISABLED = 2'h0;
    localparam logic [1:0] FMT_AC_DIFF = 2'h1;
    localparam logic [1:0] FMT_HCSL = 2'h2;
    localparam logic [1:0] FMT_LVCMOS = 2'h3;

    // reset values and writable masks, reserved bits are outside the masks
    localparam logic [7:0] REF_CTL_RST = 8'h06;
    localparam logic [7:0] CHANNEL_POWER_DOWN_RST = 8'h00;
    localparam logic [7:0] OUT0_RST = 8'hB0;
    localparam logic [7:0] REF_CTL_MASK = 8'hBF;
    localparam logic [7:0] CHANNEL_POWER_DOWN_MASK = 8'h7F;
    localparam logic [7:0] OUT0_MASK = 8'hFE;
    localparam logic [7:0] MUX_OFF_RST = 8'h00;

endpackage

// ===== hw/ref_detect_if.sv
// interface between the register bank and one reference loss-of-signal gate
// assumes both ends run on hclk
`timescale 1ns/1ps
interface ref_detect_if;
    logic bypass; // detector bypass from the register bank
    logic valid; // input valid as seen by the pll control logic
    logic los; // filtered true detector result for status and interrupt
    modport detect (input bypass, output valid, output los);
    modport ctrl (output bypass, input valid, input los);
endinterface

// ===== hw/los_gate.sv
// loss-of-signal synchroniser and bypass gate for one reference input
// assumes the detector pin is asynchronous to hclk
`timescale 1ns/1ps
module los_gate
(
    input wire logic hclk, // register clock
    input wire logic hresetn, // async reset, active low
    input wire logic los_pin, // raw detector result, high on loss
    ref_detect_if.detect det // bypass in, valid and status out
);
    import clk_cfg_pkg::*;

    typedef struct packed {
        logic [2:0] sync;
        logic los;
        logic valid;
    } gate_state_t;

    gate_state_t state_r;
    gate_state_t state_nxt;

    // stage 0 feeds stage 1 only; a change counts once stages 1 and 2 agree
    always_comb
    begin
        state_nxt = state_r;
        state_nxt.sync = {state_r.sync[1:0], los_pin};
        if (state_r.sync[2] == state_r.sync[1])
        begin
            state_nxt.los = state_r.sync[1];
        end
        state_nxt.valid = det.bypass | ~state_nxt.los;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_r <= '{sync: 3'h0, los: 1'b0, valid: 1'b1};
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign det.valid = state_r.valid;
    // status keeps the true result whatever the bypass says
    assign det.los = state_r.los;

endmodule // los_gate

// ===== hw/clock_input_output_config_regs.sv
// reference input, channel power-down and output zero configuration registers
// assumes an AHB-Lite master doing single word transfers; one slave on the bus
//
// Operation
// - with the detector bypass set, both reference inputs are reported valid to the pll logic.
// - the bypass leaves the status and interrupt view of the detectors untouched.
// - bit 5 of the input register selects the 50 ohm ground termination on the secondary input.
// - bit 4 of the input register selects the ground termination on the primary input.
// - bit 3 of the input register enables the 100 ohm differential secondary termination.
// - bit 2 of the input register enables the differential primary termination, reset 1.
// - bit 1 of the input register enables ac-coupling bias on the secondary input, reset 1.
// - bit 0 of the input register enables ac-coupling bias on the primary input, reset 0.
// - power-down bits 2 to 5 stop the mux and divider of channels 4 to 7, buffers untouched.
// - power-down bit 1 stops channels 2 and 3, bit 0 stops channels 0 and 1.
// - bit 7 of output zero control picks pll1 at 0 and pll2 at 1 for channels 0 and 1.
// - bits 6:5 of output zero control pick the driver format, reset 0x1.
// - bits 4:3 set the tail current or positive cmos pin, reset 0x2.
// - bits 2:1 set the hcsl load or negative cmos pin, reset 0x0.
`timescale 1ns/1ps
module clock_input_output_config_regs
(
    input wire logic hclk, // bus clock, 125 MHz
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size, word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready in
    output logic hreadyout, // slave ready
    output logic [31:0] hrdata, // read data
    output logic hresp, // always okay
    input wire logic primary_los_pin, // primary detector, high on loss
    input wire logic secondary_los_pin, // secondary detector, high on loss
    output logic primary_ref_valid, // primary usable by pll control
    output logic secondary_ref_valid, // secondary usable by pll control
    output logic primary_los_status, // true primary loss for status
    output logic secondary_los_status, // true secondary loss for status
    output logic signal_detect_bypass, // detector bypass setting
    output logic secondary_ground_termination, // secondary 50 ohm to ground
    output logic primary_ground_termination, // primary termination to ground
    output logic secondary_diff_termination, // secondary 100 ohm differential
    output logic primary_diff_termination, // primary differential termination
    output logic secondary_ac_bias, // secondary ac-coupling bias
    output logic primary_ac_bias, // primary ac-coupling bias
    output logic cmos_channel_off, // cmos output channel power-down
    output logic [7:0] channel_mux_off, // per channel mux and divider stop
    output logic pair_zero_one_source_select, // 0 pll1, 1 pll2
    output logic [1:0] output_zero_format, // driver format code
    output logic [1:0] output_zero_first_mode, // tail current or p pin
    output logic [1:0] output_zero_second_mode // hcsl load or n pin
);
    import clk_cfg_pkg::*;

    typedef struct packed {
        logic [7:0] ref_ctl;
        logic [7:0] channel_power_down;
        logic [7:0] out0;
        logic [7:0] mux_off;
        logic wr_pend;
        logic [1:0] wr_sel;
        logic [31:0] rdata;
        logic ready;
        logic resp;
    } bank_state_t;

    bank_state_t state_r;
    bank_state_t state_nxt;
    logic [1:0] addr_sel;
    logic [7:0] wbyte;

    ref_detect_if pri_det ();
    ref_detect_if sec_det ();

    // address decode, anything else is unmapped and reads zero
    always_comb
    begin
        if (haddr == REF_CTL_ADDR)
        begin
            addr_sel = SEL_REF;
        end
        else if (haddr == CHANNEL_POWER_DOWN_ADDR)
        begin
            addr_sel = SEL_CHANNEL_POWER_DOWN;
        end
        else if (haddr == OUT0_ADDR)
        begin
            addr_sel = SEL_OUT0;
        end
        else
        begin
            addr_sel = SEL_NONE;
        end
    end

    assign wbyte = hwdata[7:0];

    // the write lands at the end of its data phase; a read issued in that same cycle
    // reads the next-state copy so it never sees the stale value
    always_comb
    begin
        state_nxt = state_r;
        state_nxt.ready = 1'b1;
        state_nxt.resp = 1'b0;
        state_nxt.wr_pend = 1'b0;
        if (state_r.wr_pend)
        begin
            case (state_r.wr_sel)
                SEL_REF:
                begin
                    state_nxt.ref_ctl = wbyte & REF_CTL_MASK;
                end
                SEL_CHANNEL_POWER_DOWN:
                begin
                    state_nxt.channel_power_down = wbyte & CHANNEL_POWER_DOWN_MASK;
                end
                SEL_OUT0:
                begin
                    state_nxt.out0 = wbyte & OUT0_MASK;
                end
                default:
                begin
                    state_nxt.out0 = state_r.out0; // unmapped write dropped
                end
            endcase
        end
        // pair bits stop two channels each, single bits one channel each
        state_nxt.mux_off[0] = state_nxt.channel_power_down[CHANNEL_POWER_DOWN_CH01_BIT];
        state_nxt.mux_off[1] = state_nxt.channel_power_down[CHANNEL_POWER_DOWN_CH01_BIT];
        state_nxt.mux_off[2] = state_nxt.channel_power_down[CHANNEL_POWER_DOWN_CH23_BIT];
        state_nxt.mux_off[3] = state_nxt.channel_power_down[CHANNEL_POWER_DOWN_CH23_BIT];
        state_nxt.mux_off[4] = state_nxt.channel_power_down[CHANNEL_POWER_DOWN_CH4_BIT];
        state_nxt.mux_off[5] = state_nxt.channel_power_down[CHANNEL_POWER_DOWN_CH5_BIT];
        state_nxt.mux_off[6] = state_nxt.channel_power_down[CHANNEL_POWER_DOWN_CH6_BIT];
        state_nxt.mux_off[7] = state_nxt.channel_power_down[CHANNEL_POWER_DOWN_CH7_BIT];
        if (hsel && htrans[1] && hready)
        begin
            if (hwrite)
            begin
                state_nxt.wr_pend = 1'b1;
                state_nxt.wr_sel = addr_sel;
            end
            else
            begin
                case (addr_sel)
                    SEL_REF:
                    begin
                        state_nxt.rdata = {24'h000000, state_nxt.ref_ctl};
                    end
                    SEL_CHANNEL_POWER_DOWN:
                    begin
                        state_nxt.rdata = {24'h000000, state_nxt.channel_power_down};
                    end
                    SEL_OUT0:
                    begin
                        state_nxt.rdata = {24'h000000, state_nxt.out0};
                    end
                    default:
                    begin
                        state_nxt.rdata = 32'h00000000;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_r <= '{ref_ctl: REF_CTL_RST, channel_power_down: CHANNEL_POWER_DOWN_RST, out0: OUT0_RST,
                         mux_off: MUX_OFF_RST, wr_pend: 1'b0, wr_sel: SEL_NONE,
                         rdata: 32'h00000000, ready: 1'b1, resp: 1'b0};
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // one gate per reference input; bypass is shared, status stays honest
    assign pri_det.bypass = state_r.ref_ctl[REF_BYPASS_BIT];
    assign sec_det.bypass = state_r.ref_ctl[REF_BYPASS_BIT];

    los_gate pri_gate
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .los_pin(primary_los_pin),
        .det(pri_det)
    );

    los_gate sec_gate
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .los_pin(secondary_los_pin),
        .det(sec_det)
    );

    // bus outputs
    assign hreadyout = state_r.ready;
    assign hrdata = state_r.rdata;
    assign hresp = state_r.resp;

    // detector views
    assign primary_ref_valid = pri_det.valid;
    assign secondary_ref_valid = sec_det.valid;
    assign primary_los_status = pri_det.los;
    assign secondary_los_status = sec_det.los;

    // input buffer settings
    assign signal_detect_bypass = state_r.ref_ctl[REF_BYPASS_BIT];
    assign secondary_ground_termination = state_r.ref_ctl[REF_SEC_GND_BIT];
    assign primary_ground_termination = state_r.ref_ctl[REF_PRI_GND_BIT];
    assign secondary_diff_termination = state_r.ref_ctl[REF_SEC_DIFF_BIT];
    assign primary_diff_termination = state_r.ref_ctl[REF_PRI_DIFF_BIT];
    assign secondary_ac_bias = state_r.ref_ctl[REF_SEC_AC_BIT];
    assign primary_ac_bias = state_r.ref_ctl[REF_PRI_AC_BIT];

    // channel stops reach mux and divider only; buffers follow the format field
    assign cmos_channel_off = state_r.channel_power_down[CHANNEL_POWER_DOWN_CMOS_BIT];
    assign channel_mux_off = state_r.mux_off;

    // output zero driver, format 0 disables the driver only; the mux and divider follow power-down bit 0
    assign pair_zero_one_source_select = state_r.out0[OUT0_SRC_BIT];
    assign output_zero_format = state_r.out0[OUT0_FMT_HI:OUT0_FMT_LO];
    assign output_zero_first_mode = state_r.out0[OUT0_M1_HI:OUT0_M1_LO];
    assign output_zero_second_mode = state_r.out0[OUT0_M2_HI:OUT0_M2_LO];

endmodule // clock_input_output_config_regs

// ===== bench/clock_input_output_config_regs_checker.sv
// assertions on the bus and setting pins of the clock configuration bank
// assumes zero wait single word transfers and registered setting outputs
`timescale 1ns/1ps
module clock_input_output_config_regs_checker
    import clk_cfg_pkg::*;
(
    input wire logic hclk, // clock
    input wire logic hresetn, // reset
    input wire logic hsel, // select
    input wire logic [31:0] haddr, // address
    input wire logic [1:0] htrans, // type
    input wire logic hwrite, // write
    input wire logic [31:0] hwdata, // wdata
    input wire logic hready, // ready in
    input wire logic hreadyout, // ready out
    input wire logic [31:0] hrdata, // rdata
    input wire logic hresp, // resp
    input wire logic primary_los_pin, // det
    input wire logic secondary_los_pin, // det
    input wire logic primary_ref_valid, // valid
    input wire logic secondary_ref_valid, // valid
    input wire logic primary_los_status, // status
    input wire logic secondary_los_status, // status
    input wire logic signal_detect_bypass, // cfg
    input wire logic secondary_ground_termination, // cfg
    input wire logic primary_ground_termination, // cfg
    input wire logic secondary_diff_termination, // cfg
    input wire logic primary_diff_termination, // cfg
    input wire logic secondary_ac_bias, // cfg
    input wire logic primary_ac_bias, // cfg
    input wire logic cmos_channel_off, // cfg
    input wire logic [7:0] channel_mux_off, // cfg
    input wire logic pair_zero_one_source_select, // cfg
    input wire logic [1:0] output_zero_format, // cfg
    input wire logic [1:0] output_zero_first_mode, // cfg
    input wire logic [1:0] output_zero_second_mode // cfg
);
    logic take;
    logic [7:0] ref_v, channel_power_down_v, out_v;
    logic [31:0] a_q, wd_q, rd_exp;
    // register views rebuilt from the setting pins
    assign take = hsel && htrans[1] && hready;
    assign ref_v = {signal_detect_bypass, 1'b0, secondary_ground_termination,
        primary_ground_termination, secondary_diff_termination, primary_diff_termination,
        secondary_ac_bias, primary_ac_bias};
    assign channel_power_down_v = {1'b0, cmos_channel_off, channel_mux_off[7:4], channel_mux_off[2],
        channel_mux_off[0]};
    assign out_v = {pair_zero_one_source_select, output_zero_format, output_zero_first_mode,
        output_zero_second_mode, 1'b0};
    assign rd_exp = a_q == REF_CTL_ADDR ? {24'h000000, ref_v} : a_q == CHANNEL_POWER_DOWN_ADDR ?
        {24'h000000, channel_power_down_v} : a_q == OUT0_ADDR ? {24'h000000, out_v} : 32'h00000000;
    // last address and write data, so data-phase checks see the address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            a_q <= 32'h00000000;
            wd_q <= 32'h00000000;
        end
        else
        begin
            a_q <= haddr;
            wd_q <= hwdata;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_RESET_VALUES: assert property ($rose(hresetn) |-> ref_v == 8'h06
        && channel_power_down_v == 8'h00 && out_v == 8'hB0 && channel_mux_off == 8'h00)
        else $error("setting pins differ from reset values");
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("slave stalled or answered with an error");
    AST_REF_WRITE: assert property ((take && hwrite && haddr == REF_CTL_ADDR) ##1 1
        |=> ref_v == (wd_q[7:0] & 8'hBF)) else $error("input control write not on pins");
    AST_CHANNEL_POWER_DOWN_WRITE: assert property ((take && hwrite && haddr == CHANNEL_POWER_DOWN_ADDR) ##1 1
        |=> channel_mux_off == {wd_q[5:2], {2{wd_q[1]}}, {2{wd_q[0]}}}
        && cmos_channel_off == wd_q[6]) else $error("power-down write not on pins");
    AST_OUT0_WRITE: assert property ((take && hwrite && haddr == OUT0_ADDR) ##1 1
        |=> out_v == (wd_q[7:0] & 8'hFE)) else $error("output zero write not on pins");
    AST_READ_DATA: assert property ((take && !hwrite) |=> hrdata == rd_exp)
        else $error("read data differs from register view");
    AST_BYPASS_VALID: assert property (signal_detect_bypass |=>
        primary_ref_valid && secondary_ref_valid) else $error("bypass did not force valid");
    AST_PRI_LOSS_SEEN: assert property (primary_los_pin [*5] |-> primary_los_status)
        else $error("primary loss missing from status");
    AST_PRI_LOSS_BLOCKS: assert property ((primary_los_pin && !signal_detect_bypass) [*5]
        |-> !primary_ref_valid) else $error("primary loss not blocking valid");
    AST_SEC_LOSS_CLEAR: assert property ((!secondary_los_pin) [*5] |->
        !secondary_los_status && secondary_ref_valid) else $error("secondary clear not seen");
    COV_OUT0_WRITE: cover property (take && hwrite && haddr == OUT0_ADDR);
    COV_UNMAPPED_READ: cover property (take && !hwrite && haddr == 32'h00000080);
    COV_BYPASS_LOSS: cover property (signal_detect_bypass && primary_los_status);
endmodule // clock_input_output_config_regs_checker

bind clock_input_output_config_regs clock_input_output_config_regs_checker checker_i (.*);

// ===== bench/clock_input_output_config_regs_bench.sv
// self-checking bench for the clock configuration register bank
// assumes the bank is the only slave, so its ready out is the bus ready
`timescale 1ns/1ps
module clock_input_output_config_regs_bench;
    import clk_cfg_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic primary_los_pin = 1'b0, secondary_los_pin = 1'b0;
    logic primary_ref_valid, secondary_ref_valid, primary_los_status, secondary_los_status;
    logic signal_detect_bypass, secondary_ground_termination, primary_ground_termination;
    logic secondary_diff_termination, primary_diff_termination, secondary_ac_bias, primary_ac_bias;
    logic cmos_channel_off, pair_zero_one_source_select;
    logic [7:0] channel_mux_off;
    logic [1:0] output_zero_format, output_zero_first_mode, output_zero_second_mode;
    logic [31:0] addrs [3] = '{32'h74, 32'h78, 32'h7C};
    logic [7:0] masks [3] = '{8'hBF, 8'h7F, 8'hFE};
    logic [7:0] obs [3];
    int fails = 0, comparisons = 0, cycles = 0;
    clock_input_output_config_regs clock_input_output_config_regs_i (.*);
    // views of each register as seen on the setting pins
    assign hready = hreadyout;
    assign obs[0] = {signal_detect_bypass, 1'b0, secondary_ground_termination,
        primary_ground_termination, secondary_diff_termination, primary_diff_termination,
        secondary_ac_bias, primary_ac_bias};
    assign obs[1] = {1'b0, cmos_channel_off, channel_mux_off[7:4], channel_mux_off[2],
        channel_mux_off[0]};
    assign obs[2] = {pair_zero_one_source_select, output_zero_format, output_zero_first_mode,
        output_zero_second_mode, 1'b0};
    always #4 hclk = ~hclk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // one transfer; each phase held until ready is seen at an edge
    task automatic bus(input logic [31:0] a, input logic w, input logic [7:0] v);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, v};
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    // read back one register and compare both the bus and its pins
    task automatic rc(input int r, input logic [7:0] e);
        bus(addrs[r], 1'b0, 8'h00);
        check(rd, {24'h000000, e});
        check({24'h000000, obs[r]}, {24'h000000, e});
        if (r == 1)
            check({24'h000000, channel_mux_off}, {24'h0, e[5:2], {2{e[1]}}, {2{e[0]}}});
    endtask
    // hang guard, far above the roughly 150 cycles the sequence needs
    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            fails = fails + 1;
            complete_run();
        end
    end
    initial
    begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rc(0, 8'h06);
        rc(1, 8'h00);
        rc(2, 8'hB0);
        // walking one, reserved bits must read back clear
        for (int r = 0; r < 3; r++)
            for (int i = 0; i < 8; i++)
            begin
                bus(addrs[r], 1'b1, 8'h01 << i);
                rc(r, (8'h01 << i) & masks[r]);
            end
        // every format code with mode fields and source varied
        for (int c = 0; c < 4; c++)
        begin
            bus(32'h7C, 1'b1, {c[0], c[1:0], ~c[1:0], c[1:0], 1'b1});
            rc(2, {c[0], c[1:0], ~c[1:0], c[1:0], 1'b0});
        end
        // unmapped places answer zero and leave the bank alone
        bus(32'h80, 1'b1, 8'hFF);
        bus(32'h80, 1'b0, 8'h00);
        check(rd, 32'h0);
        rc(2, 8'hE6);
        // loss on both inputs; bypass hides it from the pll side only
        bus(32'h74, 1'b1, 8'h06);
        primary_los_pin <= 1'b1;
        secondary_los_pin <= 1'b1;
        repeat (8) @(posedge hclk);
        check({30'h0, primary_ref_valid, secondary_ref_valid}, 32'h0);
        check({30'h0, primary_los_status, secondary_los_status}, 32'h3);
        bus(32'h74, 1'b1, 8'h86);
        repeat (2) @(posedge hclk);
        check({30'h0, primary_ref_valid, secondary_ref_valid}, 32'h3);
        check({30'h0, primary_los_status, secondary_los_status}, 32'h3);
        primary_los_pin <= 1'b0;
        secondary_los_pin <= 1'b0;
        repeat (8) @(posedge hclk);
        check({30'h0, primary_los_status, secondary_los_status}, 32'h0);
        complete_run();
    end
endmodule // clock_input_output_config_regs_bench
